// [common/lwc_pkg.sv]
// constants and types shared by the lin mode and wake-up control block
package lwc_pkg;
  // counter width, wide enough for the dominant time-out count
  localparam int unsigned CNT_W = 22;

  // reference clock period
  localparam int unsigned CLK_PERIOD_NS = 20;

  // least transmit-high time that releases the driver (longer than 10 us)
  localparam int unsigned TX_HIGH_NS  = 10000;
  localparam int unsigned TX_HIGH_CYC = (TX_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // least local wake high time that re-arms local wake (longer than 6 us)
  localparam int unsigned WAKE_REARM_NS  = 6000;
  localparam int unsigned WAKE_REARM_CYC =
    (WAKE_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // transmit dominant time-out, 40 ms
  localparam int unsigned DOM_TIMEOUT_MS  = 40;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;

  // filter counts with no printed figure, plain defaults
  localparam int unsigned WAKE_FILT_CYC  = 1000;
  localparam int unsigned BUS_FILT_CYC   = 1000;
  localparam int unsigned MON_CYC        = 4000;
  localparam int unsigned BUS_REARM_CYC  = 100;
  localparam int unsigned SLEEP_FILT_CYC = 100;
  localparam int unsigned NORM_FILT_CYC  = 100;

  // event fifo shape
  localparam int unsigned EVT_DEPTH = 32;

  // operating modes
  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_FAILSAFE,
    MODE_NORMAL
  } lwc_mode_t;

  // cause of a departure from sleep
  typedef enum logic [1:0] {
    SRC_REMOTE,
    SRC_LOCAL,
    SRC_SUPPLY
  } lwc_src_t;

  // wake event record handed to the host side
  typedef struct packed {
    lwc_src_t src;
    logic     to_normal;
  } lwc_evt_t;
endpackage

// [verilog/lwc_mode_wake.sv]
// lin transceiver mode sequencing, wake filtering and wake event fifo

// small fifo holding wake event records
module lwc_fifo #(
  parameter int unsigned WIDTH = 3,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
  assign out_valid = (wr_q != rd_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q[AW-1:0]];

  // pointers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // storage needs no reset, empty pointers hide it
  always_ff @(posedge ref_clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// mode and wake-up control top
module lwc_mode_wake #(
  parameter bit          TIMEOUT_EN      = 1'b1,
  parameter int unsigned DOM_TIMEOUT_CYC = lwc_pkg::DOM_TIMEOUT_CYC,
  parameter int unsigned WAKE_FILT_CYC   = lwc_pkg::WAKE_FILT_CYC,
  parameter int unsigned BUS_FILT_CYC    = lwc_pkg::BUS_FILT_CYC,
  parameter int unsigned MON_CYC         = lwc_pkg::MON_CYC,
  parameter int unsigned BUS_REARM_CYC   = lwc_pkg::BUS_REARM_CYC,
  parameter int unsigned SLEEP_FILT_CYC  = lwc_pkg::SLEEP_FILT_CYC,
  parameter int unsigned NORM_FILT_CYC   = lwc_pkg::NORM_FILT_CYC,
  parameter int unsigned EVT_DEPTH       = lwc_pkg::EVT_DEPTH
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              tx_in,
  output logic                   txd_out,
  output logic                   txd_oe_n,
  output logic                   txd_weak_pd,
  input  wire logic              mode_sel_in,
  input  wire logic              wake_sw_n,
  input  wire logic              bus_dominant,
  input  wire logic              pre_wake_low_level,
  input  wire logic              pre_wake_high_level,
  input  wire logic              supply_ok,
  input  wire logic              over_temp,
  input  wire logic              temp_cooled,
  output logic                   rxd_out,
  output logic                   rxd_oe_n,
  output logic                   bus_drive,
  output logic                   termination_on,
  output logic                   bus_receiver_on,
  output logic                   regulator_inhibit_out,
  output logic                   regulator_inhibit_oe_n,
  output lwc_pkg::lwc_mode_t     mode_out,
  output logic                   evt_valid,
  input  wire logic              evt_ready,
  output lwc_pkg::lwc_evt_t      evt_data
);
  localparam int unsigned CW = lwc_pkg::CNT_W;
  // whole block state
  typedef struct packed {
    lwc_pkg::lwc_mode_t mode;
    logic               en_f;
    logic [CW-1:0]      en_cnt;
    logic               rx_on;
    logic               rem_armed;
    logic               dom_seen;
    logic               long_dom;
    logic [CW-1:0]      mon_cnt;
    logic [CW-1:0]      bus_cnt;
    logic [CW-1:0]      hi_cnt;
    logic               loc_armed;
    logic [CW-1:0]      wk_cnt;
    logic [CW-1:0]      wkhi_cnt;
    logic               wake_req;
    logic               wake_local;
    logic               tx_en;
    logic [CW-1:0]      txhi_cnt;
    logic               dom_to;
    logic [CW-1:0]      dom_cnt;
    logic               ot_off;
    logic               evt_pend;
    lwc_pkg::lwc_evt_t  evt;
    logic               rxd_low;
    logic               drive;
    logic               inh_on;
    logic               strong_pd;
    logic               weak_pd;
    logic               term_on;
  } lwc_state_t;

  lwc_state_t st_q;
  lwc_state_t st_d;
  logic       fifo_in_ready;
  logic       en_rise;
  logic       en_fall;
  logic       remote_wake;
  logic       local_wake;
  // saturating count so long levels never wrap
  function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  always_comb begin
    st_d        = st_q;
    en_rise     = 1'b0;
    en_fall     = 1'b0;
    remote_wake = 1'b0;
    local_wake  = 1'b0;
    // mode-select filter, own time for each direction
    if (mode_sel_in != st_q.en_f) begin
      st_d.en_cnt = sat_inc(st_q.en_cnt);
      if (st_d.en_cnt >= (st_q.en_f ? SLEEP_FILT_CYC : NORM_FILT_CYC)) begin
        st_d.en_f   = mode_sel_in;
        st_d.en_cnt = '0;
        en_rise     = mode_sel_in;
        en_fall     = !mode_sel_in;
      end
    end else begin
      st_d.en_cnt = '0;
    end
    // thermal switch-off held until the cooled comparator reports
    if (over_temp) begin
      st_d.ot_off = 1'b1;
    end else if (temp_cooled) begin
      st_d.ot_off = 1'b0;
    end
    // transmit high and low run lengths
    st_d.txhi_cnt = tx_in ? sat_inc(st_q.txhi_cnt) : '0;
    st_d.dom_cnt  = tx_in ? '0 : sat_inc(st_q.dom_cnt);
    if (TIMEOUT_EN && st_q.dom_cnt >= DOM_TIMEOUT_CYC) begin
      st_d.dom_to = 1'b1;
    end else if (st_q.txhi_cnt >= lwc_pkg::TX_HIGH_CYC) begin
      st_d.dom_to = 1'b0;
    end
    // local wake re-arm after a long enough high
    if (wake_sw_n) begin
      st_d.wk_cnt   = '0;
      st_d.wkhi_cnt = sat_inc(st_q.wkhi_cnt);
      if (st_q.wkhi_cnt >= lwc_pkg::WAKE_REARM_CYC) st_d.loc_armed = 1'b1;
    end else begin
      st_d.wkhi_cnt = '0;
    end
    // remote wake re-arm after bus sits above pre-wake high
    if (pre_wake_high_level && !st_q.rem_armed) begin
      st_d.hi_cnt = sat_inc(st_q.hi_cnt);
      if (st_q.hi_cnt >= BUS_REARM_CYC) st_d.rem_armed = 1'b1;
    end else begin
      st_d.hi_cnt = '0;
    end
    // event hand-off to the fifo, a new set below wins over this clear
    if (st_q.evt_pend && fifo_in_ready) st_d.evt_pend = 1'b0;
    unique case (st_q.mode)
      lwc_pkg::MODE_SLEEP: begin
        // local filter: low after an armed (high) period
        if (!wake_sw_n && st_q.loc_armed) begin
          st_d.wk_cnt = sat_inc(st_q.wk_cnt);
          if (st_q.wk_cnt >= WAKE_FILT_CYC) local_wake = 1'b1;
        end
        // receiver wakes on pre-wake low, monitor window starts
        if (!st_q.rx_on && !st_q.long_dom) begin
          if (pre_wake_low_level && st_q.rem_armed) begin
            st_d.rx_on   = 1'b1;
            st_d.mon_cnt = '0;
            st_d.bus_cnt = '0;
          end
        end else if (st_q.rx_on) begin
          st_d.mon_cnt = sat_inc(st_q.mon_cnt);
          if (bus_dominant) begin
            st_d.bus_cnt = sat_inc(st_q.bus_cnt);
            if (st_q.bus_cnt >= BUS_FILT_CYC) st_d.dom_seen = 1'b1;
          end else begin
            // rising edge after a filtered dominant is a wake
            if (st_q.dom_seen) remote_wake = 1'b1;
            st_d.bus_cnt  = '0;
            st_d.dom_seen = 1'b0;
          end
          if (!remote_wake && st_q.mon_cnt >= MON_CYC) begin
            // window over: receiver off either way
            st_d.rx_on    = 1'b0;
            st_d.dom_seen = 1'b0;
            if (bus_dominant) begin
              st_d.long_dom = 1'b1;
            end else begin
              st_d.rem_armed = 1'b0;
            end
          end
        end else if (!bus_dominant) begin
          // release of a long dominant or short goes straight to wake
          remote_wake   = 1'b1;
          st_d.long_dom = 1'b0;
        end
        // exits from sleep, undervoltage first
        if (!supply_ok) begin
          st_d.mode     = lwc_pkg::MODE_FAILSAFE;
          st_d.evt_pend = 1'b1;
          st_d.evt      = '{src: lwc_pkg::SRC_SUPPLY, to_normal: 1'b0};
        end else if (remote_wake || local_wake) begin
          st_d.mode       = lwc_pkg::MODE_FAILSAFE;
          st_d.wake_req   = 1'b1;
          st_d.wake_local = local_wake && !remote_wake;
          st_d.evt_pend   = 1'b1;
          st_d.evt.src    = local_wake && !remote_wake ? lwc_pkg::SRC_LOCAL
                                                        : lwc_pkg::SRC_REMOTE;
          st_d.evt.to_normal = 1'b0;
        end else if (st_d.en_f) begin
          st_d.mode     = lwc_pkg::MODE_NORMAL;
          st_d.tx_en    = 1'b0;
          st_d.txhi_cnt = '0;
          st_d.evt_pend = 1'b1;
          st_d.evt      = '{src: lwc_pkg::SRC_REMOTE, to_normal: 1'b1};
        end
        if (local_wake) st_d.loc_armed = 1'b0;
        if (st_d.mode != lwc_pkg::MODE_SLEEP) begin
          st_d.rx_on    = 1'b0;
          st_d.long_dom = 1'b0;
          st_d.dom_seen = 1'b0;
        end
      end
      lwc_pkg::MODE_FAILSAFE: begin
        // host confirms with a high mode-select; flags drop at once
        if (st_d.en_f) begin
          st_d.mode       = lwc_pkg::MODE_NORMAL;
          st_d.wake_req   = 1'b0;
          st_d.wake_local = 1'b0;
          st_d.tx_en      = 1'b0;
          st_d.txhi_cnt   = '0;
        end
      end
      lwc_pkg::MODE_NORMAL: begin
        // driver held off until transmit proves high
        if (st_q.txhi_cnt >= lwc_pkg::TX_HIGH_CYC) st_d.tx_en = 1'b1;
        // sleep on a filtered fall with transmit high, bus ignored
        if (en_fall && tx_in) begin
          st_d.mode    = lwc_pkg::MODE_SLEEP;
          st_d.rx_on   = 1'b0;
          st_d.mon_cnt = '0;
          st_d.bus_cnt = '0;
          st_d.wk_cnt  = '0;
        end
      end
    endcase
    // pin controls, registered from the next mode
    st_d.term_on   = st_d.mode != lwc_pkg::MODE_SLEEP;
    st_d.inh_on    = st_d.mode != lwc_pkg::MODE_SLEEP && supply_ok;
    st_d.strong_pd = st_d.mode == lwc_pkg::MODE_FAILSAFE && st_d.wake_req
                     && st_d.wake_local;
    st_d.weak_pd   = st_d.mode == lwc_pkg::MODE_FAILSAFE && st_d.wake_req
                     && !st_d.wake_local;
    st_d.rxd_low   = (st_d.mode == lwc_pkg::MODE_FAILSAFE && st_d.wake_req)
                     || (st_d.mode == lwc_pkg::MODE_NORMAL && bus_dominant);
    // open transmit reads high through its pull-up, so a floating pin never drives
    st_d.drive     = st_d.mode == lwc_pkg::MODE_NORMAL && st_d.tx_en && !tx_in
                     && !st_d.dom_to && !st_d.ot_off && supply_ok;
  end

  // power-on lands in fail-safe with no wake flag
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q           <= '0;
      st_q.mode      <= lwc_pkg::MODE_FAILSAFE;
      st_q.rem_armed <= 1'b1;
      st_q.term_on   <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // the fifo stalls the pending record; a newer event overwrites one still waiting
  lwc_fifo #(
    .WIDTH($bits(lwc_pkg::lwc_evt_t)),
    .DEPTH(EVT_DEPTH)
  ) u_evt_fifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .in_valid (st_q.evt_pend),
    .in_ready (fifo_in_ready),
    .in_data  (st_q.evt),
    .out_valid(evt_valid),
    .out_ready(evt_ready),
    .out_data (evt_data)
  );

  // pins; open-drain style enables are low while driving
  assign txd_out                = 1'b0;
  assign txd_oe_n               = !st_q.strong_pd;
  assign txd_weak_pd            = st_q.weak_pd;
  assign rxd_out                = 1'b0;
  assign rxd_oe_n               = !st_q.rxd_low;
  assign bus_drive              = st_q.drive;
  assign termination_on         = st_q.term_on;
  assign bus_receiver_on        = st_q.rx_on || st_q.mode != lwc_pkg::MODE_SLEEP;
  assign regulator_inhibit_out  = 1'b1;
  assign regulator_inhibit_oe_n = !st_q.inh_on;
  assign mode_out               = st_q.mode;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence seq_enter_normal;
    $changed(st_q.mode) && st_q.mode == lwc_pkg::MODE_NORMAL;
  endsequence
  sequence seq_new_wake;
    $rose(st_q.wake_req);
  endsequence
  a_sleep_no_drive: assert property (
    st_q.mode == lwc_pkg::MODE_SLEEP |-> !bus_drive)
    else $error("bus driven during sleep");
  // the filtered rise and the mode step land on the same edge
  a_confirm_normal: assert property (
    $rose(st_q.en_f) && $past(st_q.mode) == lwc_pkg::MODE_FAILSAFE
    |-> st_q.mode == lwc_pkg::MODE_NORMAL)
    else $error("fail-safe did not enter normal");
  a_sleep_pins: assert property (
    st_q.mode == lwc_pkg::MODE_SLEEP |-> regulator_inhibit_oe_n && !termination_on)
    else $error("inhibit or termination active in sleep");
  a_wake_report: assert property (
    seq_new_wake |-> st_q.mode == lwc_pkg::MODE_FAILSAFE && !rxd_oe_n
    && !regulator_inhibit_oe_n == supply_ok && termination_on)
    else $error("wake not reported on receive output");
  a_local_pull: assert property (
    seq_new_wake ##0 st_q.wake_local |-> !txd_oe_n && !txd_weak_pd)
    else $error("local wake lacks strong pull-down");
  a_remote_pull: assert property (
    seq_new_wake ##0 !st_q.wake_local |-> txd_oe_n && txd_weak_pd)
    else $error("remote wake lacks weak pull-down");
  a_flags_clear: assert property (
    seq_enter_normal |-> !st_q.wake_req && txd_oe_n && !txd_weak_pd)
    else $error("wake flags survive normal entry");
  a_driver_hold: assert property (
    seq_enter_normal |-> (!bus_drive)[*8])
    else $error("driver enabled too soon after normal entry");
  a_thermal_off: assert property (
    st_q.ot_off |-> !bus_drive)
    else $error("driver on during over-temperature");
  a_rx_mirror: assert property (
    st_q.mode == lwc_pkg::MODE_NORMAL && bus_dominant
    |=> st_q.mode != lwc_pkg::MODE_NORMAL || !rxd_oe_n)
    else $error("receive output does not mirror dominant bus");
  a_sleep_entry: assert property (
    $fell(st_q.en_f) && $past(st_q.mode) == lwc_pkg::MODE_NORMAL && $past(tx_in)
    |-> st_q.mode == lwc_pkg::MODE_SLEEP)
    else $error("sleep request not taken");
endmodule

// [verification/lwc_bus_model.sv]
// far-side model: lin bus nodes with pull-up, host transmit pin and receive pin
module lwc_bus_model (
  input  wire logic       bus_drive,
  input  wire logic [1:0] far_state,
  input  wire logic       host_tx,
  input  wire logic       host_tx_en,
  input  wire logic       txd_oe_n,
  input  wire logic       rxd_oe_n,
  output logic            bus_dominant,
  output logic            pre_wake_low_level,
  output logic            pre_wake_high_level,
  output logic            tx_pin,
  output logic            rxd_pin
);
  timeunit 1ns;
  timeprecision 100ps;

  // far_state: 0 recessive, 1 floating between levels, 2 held dominant by a node or short
  // wired-and bus, any dominant driver beats the pull-up
  assign bus_dominant        = bus_drive | (far_state == 2'h2);
  assign pre_wake_low_level  = bus_dominant | (far_state == 2'h1);
  assign pre_wake_high_level = !pre_wake_low_level;
  // released host pin: pull-up wins over weak pull-down, loses to strong one
  assign tx_pin = host_tx_en ? host_tx : txd_oe_n;
  // open drain receive pin with pull-up
  assign rxd_pin = rxd_oe_n;
endmodule

// [verification/lin_transceiver_mode_wake_control_bench.sv]
// self-checking bench for the lin mode and wake-up control block
module lin_transceiver_mode_wake_control_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk, resetn, host_tx, host_tx_en, mode_sel_in, wake_sw_n;
  logic supply_ok, over_temp, temp_cooled, evt_ready, tx_in, rxd_pin;
  logic txd_oe_n, txd_weak_pd, rxd_oe_n, bus_drive, termination_on;
  logic bus_receiver_on, regulator_inhibit_oe_n, evt_valid;
  logic bus_dominant, pre_wake_low_level, pre_wake_high_level;
  logic [1:0]         far_state;
  lwc_pkg::lwc_mode_t mode_out;
  lwc_pkg::lwc_evt_t  evt_data;
  int                 miscompares, samples_checked, cycles;

  // short filter counts keep the run brief
  // mode-select filters keep their own default count of 100
  lwc_mode_wake #(.DOM_TIMEOUT_CYC(50), .WAKE_FILT_CYC(10), .BUS_FILT_CYC(10),
    .MON_CYC(20), .BUS_REARM_CYC(5)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .tx_in(tx_in), .txd_out(), .txd_oe_n(txd_oe_n),
    .txd_weak_pd(txd_weak_pd), .mode_sel_in(mode_sel_in), .wake_sw_n(wake_sw_n),
    .bus_dominant(bus_dominant), .pre_wake_low_level(pre_wake_low_level),
    .pre_wake_high_level(pre_wake_high_level), .supply_ok(supply_ok),
    .over_temp(over_temp), .temp_cooled(temp_cooled), .rxd_out(), .rxd_oe_n(rxd_oe_n),
    .bus_drive(bus_drive), .termination_on(termination_on),
    .bus_receiver_on(bus_receiver_on), .regulator_inhibit_out(),
    .regulator_inhibit_oe_n(regulator_inhibit_oe_n), .mode_out(mode_out),
    .evt_valid(evt_valid), .evt_ready(evt_ready), .evt_data(evt_data));

  lwc_bus_model far_end (.bus_drive(bus_drive), .far_state(far_state), .host_tx(host_tx),
    .host_tx_en(host_tx_en), .txd_oe_n(txd_oe_n), .rxd_oe_n(rxd_oe_n),
    .bus_dominant(bus_dominant), .pre_wake_low_level(pre_wake_low_level),
    .pre_wake_high_level(pre_wake_high_level), .tx_pin(tx_in), .rxd_pin(rxd_pin));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end

  // inputs always move 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic chk_src(input lwc_pkg::lwc_src_t exp, input lwc_pkg::lwc_src_t got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected event source: expected %0d, seen %0d", exp, got);
    end
  endtask

  // bounded wait for a mode; limit 0 is a plain compare
  task automatic wait_mode(input lwc_pkg::lwc_mode_t m, input int limit);
    int i;
    i = 0;
    while (mode_out !== m && i < limit) begin
      step(1);
      i++;
    end
    samples_checked++;
    if (mode_out !== m) begin
      miscompares++;
      $display("unexpected mode: expected %0d, seen %0d", m, mode_out);
    end
  endtask

  task automatic go_normal;
    host_tx_en = 1'b1;
    host_tx = 1'b1;
    mode_sel_in = 1'b1;
    wait_mode(lwc_pkg::MODE_NORMAL, 120);
  endtask

  task automatic go_sleep;
    host_tx_en = 1'b1;
    host_tx = 1'b1;
    step(2);
    mode_sel_in = 1'b0;
    wait_mode(lwc_pkg::MODE_SLEEP, 120);
  endtask

  task automatic t_reset;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 0);
    chk("termination", 1'b1, termination_on);
    chk("inhibit float", 1'b0, regulator_inhibit_oe_n);
    chk("receive pin", 1'b1, rxd_pin);
    chk("event valid", 1'b0, evt_valid);
  endtask

  task automatic t_normal_tx;
    mode_sel_in = 1'b1;
    step(2);
    mode_sel_in = 1'b0;
    step(10);
    wait_mode(lwc_pkg::MODE_FAILSAFE, 0);
    go_normal();
    host_tx = 1'b0;
    step(5);
    chk("driver", 1'b0, bus_drive);
    host_tx = 1'b1;
    step(100);
    host_tx = 1'b0;
    step(3);
    chk("driver", 1'b0, bus_drive);
    host_tx = 1'b1;
    step(520);
    host_tx = 1'b0;
    step(2);
    chk("driver", 1'b1, bus_drive);
    step(2);
    chk("receive pin", 1'b0, rxd_pin);
    // stays low past the dominant time-out
    step(60);
    chk("driver", 1'b0, bus_drive);
    host_tx = 1'b1;
    step(520);
    chk("receive pin", 1'b1, rxd_pin);
    host_tx = 1'b0;
    step(2);
    chk("driver", 1'b1, bus_drive);
    over_temp = 1'b1;
    temp_cooled = 1'b0;
    step(3);
    chk("driver", 1'b0, bus_drive);
    over_temp = 1'b0;
    step(5);
    chk("driver", 1'b0, bus_drive);
    temp_cooled = 1'b1;
    step(3);
    chk("driver", 1'b1, bus_drive);
  endtask

  task automatic t_short_sleep;
    host_tx = 1'b1;
    far_state = 2'h2;
    go_sleep();
    chk("termination", 1'b0, termination_on);
    chk("inhibit float", 1'b1, regulator_inhibit_oe_n);
    chk("driver", 1'b0, bus_drive);
    step(40);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    far_state = 2'h0;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 10);
    host_tx_en = 1'b0;
    step(1);
    chk("receive pin", 1'b0, rxd_pin);
    chk("transmit pin", 1'b1, tx_in);
    go_normal();
    chk("receive pin", 1'b1, rxd_pin);
    chk("weak pull-down", 1'b0, txd_weak_pd);
  endtask

  task automatic t_remote;
    go_sleep();
    far_state = 2'h2;
    step(3);
    far_state = 2'h0;
    // let the window close and the bus re-arm, so the real wake starts cold
    step(30);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    far_state = 2'h2;
    step(2);
    chk("receiver", 1'b1, bus_receiver_on);
    step(13);
    far_state = 2'h0;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 10);
    chk("receive pin", 1'b0, rxd_pin);
    chk("weak pull-down", 1'b1, txd_weak_pd);
    chk("termination", 1'b1, termination_on);
    chk("inhibit float", 1'b0, regulator_inhibit_oe_n);
    go_normal();
  endtask

  task automatic t_floating;
    go_sleep();
    far_state = 2'h1;
    step(40);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    chk("receiver", 1'b0, bus_receiver_on);
    far_state = 2'h2;
    step(15);
    far_state = 2'h0;
    step(3);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    step(10);
    far_state = 2'h2;
    step(15);
    far_state = 2'h0;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 10);
    go_normal();
  endtask

  task automatic t_local;
    go_sleep();
    wake_sw_n = 1'b0;
    step(3);
    wake_sw_n = 1'b1;
    step(310);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    wake_sw_n = 1'b0;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 30);
    host_tx_en = 1'b0;
    step(1);
    chk("transmit pin", 1'b0, tx_in);
    chk("receive pin", 1'b0, rxd_pin);
    go_normal();
    chk("strong pull-down", 1'b1, txd_oe_n);
    // switch still held low: sleep must hold
    go_sleep();
    step(40);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    // a high shorter than the re-arm time must not re-arm the switch
    wake_sw_n = 1'b1;
    step(100);
    wake_sw_n = 1'b0;
    step(20);
    wait_mode(lwc_pkg::MODE_SLEEP, 0);
    wake_sw_n = 1'b1;
  endtask

  task automatic t_supply;
    mode_sel_in = 1'b1;
    wait_mode(lwc_pkg::MODE_NORMAL, 120);
    go_sleep();
    supply_ok = 1'b0;
    wait_mode(lwc_pkg::MODE_FAILSAFE, 10);
    chk("inhibit float", 1'b1, regulator_inhibit_oe_n);
    supply_ok = 1'b1;
    step(2);
    chk("inhibit float", 1'b0, regulator_inhibit_oe_n);
  endtask

  // records piled up while the consumer held off; drain with stalls
  task automatic t_drain;
    lwc_pkg::lwc_src_t exp_src[6];
    int                i;
    exp_src = '{lwc_pkg::SRC_REMOTE, lwc_pkg::SRC_REMOTE, lwc_pkg::SRC_REMOTE,
                lwc_pkg::SRC_LOCAL, lwc_pkg::SRC_REMOTE, lwc_pkg::SRC_SUPPLY};
    for (int k = 0; k < 6; k++) begin
      i = 0;
      while (evt_valid !== 1'b1 && i < 10) begin
        step(1);
        i++;
      end
      chk("event valid", 1'b1, evt_valid);
      if (k != 4) begin
        chk_src(exp_src[k], evt_data.src);
      end
      chk("event to normal", k == 4, evt_data.to_normal);
      evt_ready = 1'b1;
      step(1);
      evt_ready = 1'b0;
      step(2);
    end
    chk("event valid", 1'b0, evt_valid);
  endtask

  task automatic end_of_test;
    $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, well above the expected run of about 3000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("unexpected cycle count: expected below %0d, seen %0d", 20000, cycles);
      end_of_test();
    end
  end

  initial begin
    {miscompares, samples_checked, cycles} = '0;
    resetn = 1'b0;
    {host_tx, host_tx_en, mode_sel_in, over_temp, evt_ready} = 5'h0;
    {wake_sw_n, supply_ok, temp_cooled} = 3'h7;
    far_state = 2'h0;
    repeat (12) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    host_tx_en = 1'b1;
    step(2);
    t_reset();
    t_normal_tx();
    t_short_sleep();
    t_remote();
    t_floating();
    t_local();
    t_supply();
    t_drain();
    end_of_test();
  end
endmodule
